// [bdm_pkg.sv]
`default_nettype none
// Functional notes
// - Pointer high byte bit 7 set: indirect port accesses program memory
// - Indirect read of program memory loads only the low 8 bits
// - Indirect writes aimed at program memory change nothing
// - Program memory reads through a pointer take one extra cycle
// - Data memory is 32 banks of 128 bytes
// - Bank: 12 core, 20 special, 80 general RAM, 16 common bytes
// - Direct accesses use the bank last written to the bank select register
// - Unimplemented data memory reads as zero
// - First 12 bank addresses map to the same core registers
// - Flag-setting operation targeting status: flags come from the result
// - Time-out and power-down flags ignore software writes
// - Status bits 7 to 5 always read zero
// - Time-out flag set by power-up, clear-watchdog, sleep; cleared by time-out
// - Power-down flag set by power-up or clear-watchdog; cleared by sleep
// - Zero flag follows whether the result is zero, except on rotates
// - Digit-carry flag is the carry out of bit 3 on add and subtract
// - Carry flag is the carry out of bit 7 on add and subtract
// - Subtract adds the two's complement; carries read as inverted borrows
// - Rotates through carry load carry with the bit shifted out
// - Two 16-bit pointers built from a low and a high byte
// - Program memory addresses wrap inside the implemented size
package bdm_pkg;
  localparam int BANK_COUNT = 32;
  localparam int BANK_W = 5;
  localparam int OFF_W = 7;
  localparam int GPR_BYTES = 80;
  localparam int COMMON_BYTES = 16;
  localparam int PM_WORDS_DEF = 16384;
  localparam int PM_DW = 14;
  localparam logic [6:0] OFF_IND0 = 7'h00;
  localparam logic [6:0] OFF_IND1 = 7'h01;
  localparam logic [6:0] OFF_PCL = 7'h02;
  localparam logic [6:0] OFF_STATUS = 7'h03;
  localparam logic [6:0] OFF_P0_LO = 7'h04;
  localparam logic [6:0] OFF_P0_HI = 7'h05;
  localparam logic [6:0] OFF_P1_LO = 7'h06;
  localparam logic [6:0] OFF_P1_HI = 7'h07;
  localparam logic [6:0] OFF_BSR = 7'h08;
  localparam logic [6:0] OFF_ACC = 7'h09;
  localparam logic [6:0] OFF_PCLATH = 7'h0a;
  localparam logic [6:0] OFF_INTCON = 7'h0b;
  localparam logic [6:0] OFF_SFR = 7'h0c;
  localparam logic [6:0] OFF_GPR = 7'h20;
  localparam logic [6:0] OFF_COMMON = 7'h70;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h18;
  localparam int PTR_PM_BIT = 7;
  localparam int NIB_W = 4;

  typedef enum logic [1:0] {
    CMD_READ = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_ALU = 2'b10
  } bdm_cmd_t;

  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_SUB = 3'b001,
    ALU_AND = 3'b010,
    ALU_IOR = 3'b011,
    ALU_XOR = 3'b100,
    ALU_PASS = 3'b101,
    ALU_RRC = 3'b110,
    ALU_RLC = 3'b111
  } bdm_alu_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_PM_WAIT = 1'b1
  } bdm_state_t;

  typedef struct packed {
    logic valid;
    bdm_cmd_t cmd;
    bdm_alu_t op;
    logic indirect;
    logic ptr_sel;
    logic [6:0] faddr;
    logic [7:0] operand;
    logic to_acc;
  } bdm_req_t;

  typedef struct packed {
    logic pm;
    logic ok;
    logic [4:0] bank;
    logic [6:0] off;
    logic [14:0] pm_word;
  } bdm_loc_t;
endpackage
`default_nettype wire

// [bdm_core.sv]
`default_nettype none
module bdm_core
  import bdm_pkg::*;
#(
  parameter int PM_WORDS = PM_WORDS_DEF,
  localparam int PM_AW = $clog2(PM_WORDS)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire bdm_req_t req,
  input wire logic clear_watchdog_instr,
  input wire logic sleep_instr,
  input wire logic wdt_timeout,
  input wire logic [PM_DW-1:0] pm_rdata,
  output logic busy,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic [7:0] working_accumulator,
  output logic [7:0] alu_and_reset_flags,
  output logic pm_rd,
  output logic [PM_AW-1:0] pm_addr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bdm_state_t state_q, state_d;
  bdm_req_t pend_q, pend_d;
  logic [7:0] acc_q, acc_d;
  logic [BANK_W-1:0] bsr_q, bsr_d;
  logic [1:0][15:0] ptr_q, ptr_d;
  logic [6:0] pclath_q, pclath_d;
  logic [7:0] intcon_q, intcon_d;
  logic [4:0] flags_q, flags_d;
  logic [BANK_COUNT-1:0][GPR_BYTES-1:0][7:0] gpr_q, gpr_d;
  logic [COMMON_BYTES-1:0][7:0] com_q, com_d;
  logic resp_valid_q, resp_valid_d;
  logic [7:0] resp_data_q, resp_data_d;
  logic pm_rd_q, pm_rd_d;
  logic [PM_AW-1:0] pm_addr_q, pm_addr_d;
  logic busy_q, busy_d;

  bdm_req_t act;
  bdm_loc_t loc;
  logic take;
  logic [15:0] ptr_sel_val;
  logic [7:0] rd_val, a_val, b_val, bb, alu_res, wval;
  logic [8:0] sum;
  logic [NIB_W:0] nib;
  logic alu_c, cin;
  logic [2:0] aff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Address resolution and read mux
  // ----------------------------------------------------------------
  assign take = req.valid && !busy_q;
  assign act = busy_q ? pend_q : req;
  assign ptr_sel_val = ptr_q[act.ptr_sel];

  always_comb begin
    loc.pm_word = ptr_sel_val[14:0];
    if (act.indirect) begin
      loc.pm = ptr_sel_val[8+PTR_PM_BIT];
      loc.ok = (ptr_sel_val[14:12] == 3'h0);
      loc.bank = ptr_sel_val[11:7];
      loc.off = ptr_sel_val[6:0];
    end else begin
      loc.pm = 1'b0;
      loc.ok = 1'b1;
      loc.bank = bsr_q;
      loc.off = act.faddr;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    if (loc.ok && !loc.pm) begin
      if (loc.off >= OFF_COMMON) begin
        rd_val = com_q[loc.off - OFF_COMMON];
      end else if (loc.off >= OFF_GPR) begin
        rd_val = gpr_q[loc.bank][loc.off - OFF_GPR];
      end else if (loc.off < OFF_SFR) begin
        unique case (loc.off)
          OFF_STATUS: rd_val = {3'h0, flags_q};
          OFF_P0_LO: rd_val = ptr_q[0][7:0];
          OFF_P0_HI: rd_val = ptr_q[0][15:8];
          OFF_P1_LO: rd_val = ptr_q[1][7:0];
          OFF_P1_HI: rd_val = ptr_q[1][15:8];
          OFF_BSR: rd_val = {3'h0, bsr_q};
          OFF_ACC: rd_val = acc_q;
          OFF_PCLATH: rd_val = {1'b0, pclath_q};
          OFF_INTCON: rd_val = intcon_q;
          default: rd_val = 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic unit
  // ----------------------------------------------------------------
  assign a_val = (state_q == ST_PM_WAIT) ? pm_rdata[7:0] : rd_val;
  assign b_val = act.operand;
  assign cin = (act.op == ALU_SUB);
  assign bb = cin ? ~b_val : b_val;
  assign sum = {1'b0, a_val} + {1'b0, bb} + {8'h00, cin};
  assign nib = {1'b0, a_val[NIB_W-1:0]} + {1'b0, bb[NIB_W-1:0]} + {4'h0, cin};

  always_comb begin
    alu_res = sum[7:0];
    alu_c = sum[8];
    aff = 3'b111;
    unique case (act.op)
      ALU_ADD, ALU_SUB: begin
        alu_res = sum[7:0];
      end
      ALU_AND: begin
        alu_res = a_val & b_val;
        aff = 3'b100;
      end
      ALU_IOR: begin
        alu_res = a_val | b_val;
        aff = 3'b100;
      end
      ALU_XOR: begin
        alu_res = a_val ^ b_val;
        aff = 3'b100;
      end
      ALU_PASS: begin
        alu_res = a_val;
        aff = 3'b100;
      end
      ALU_RRC: begin
        alu_res = {flags_q[ST_C], a_val[7:1]};
        alu_c = a_val[0];
        aff = 3'b001;
      end
      ALU_RLC: begin
        alu_res = {a_val[6:0], flags_q[ST_C]};
        alu_c = a_val[7];
        aff = 3'b001;
      end
    endcase
  end

  assign wval = (act.cmd == CMD_WRITE) ? b_val : alu_res;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic exec;
    exec = 1'b0;
    state_d = state_q;
    pend_d = pend_q;
    acc_d = acc_q;
    bsr_d = bsr_q;
    ptr_d = ptr_q;
    pclath_d = pclath_q;
    intcon_d = intcon_q;
    flags_d = flags_q;
    gpr_d = gpr_q;
    com_d = com_q;
    resp_valid_d = 1'b0;
    resp_data_d = resp_data_q;
    pm_rd_d = 1'b0;
    pm_addr_d = pm_addr_q;
    busy_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (take && loc.pm && req.cmd != CMD_WRITE) begin
          state_d = ST_PM_WAIT;
          pend_d = req;
          pm_rd_d = 1'b1;
          pm_addr_d = loc.pm_word[PM_AW-1:0];
          busy_d = 1'b1;
        end else if (take) begin
          exec = 1'b1;
        end
      end
      ST_PM_WAIT: begin
        exec = 1'b1;
        state_d = ST_IDLE;
      end
    endcase
    if (exec) begin
      resp_valid_d = 1'b1;
      resp_data_d = (act.cmd == CMD_READ) ? a_val : wval;
      if (act.cmd != CMD_READ && !act.to_acc && !loc.pm && loc.ok) begin
        if (loc.off >= OFF_COMMON) begin
          com_d[loc.off - OFF_COMMON] = wval;
        end else if (loc.off >= OFF_GPR) begin
          gpr_d[loc.bank][loc.off - OFF_GPR] = wval;
        end else if (loc.off < OFF_SFR) begin
          unique case (loc.off)
            OFF_STATUS: flags_d[ST_Z:ST_C] = wval[ST_Z:ST_C];
            OFF_P0_LO: ptr_d[0][7:0] = wval;
            OFF_P0_HI: ptr_d[0][15:8] = wval;
            OFF_P1_LO: ptr_d[1][7:0] = wval;
            OFF_P1_HI: ptr_d[1][15:8] = wval;
            OFF_BSR: bsr_d = wval[BANK_W-1:0];
            OFF_ACC: acc_d = wval;
            OFF_PCLATH: pclath_d = wval[6:0];
            OFF_INTCON: intcon_d = wval;
            default: ;
          endcase
        end
      end
      if (act.cmd != CMD_WRITE && act.to_acc) begin
        acc_d = (act.cmd == CMD_READ) ? a_val : alu_res;
      end
      if (act.cmd == CMD_ALU) begin
        // Flag results override any write into the status byte
        if (aff[2]) flags_d[ST_Z] = (alu_res == 8'h00);
        if (aff[1]) flags_d[ST_DC] = nib[NIB_W];
        if (aff[0]) flags_d[ST_C] = alu_c;
      end
    end
    if (clear_watchdog_instr) begin
      flags_d[ST_TO] = 1'b1;
      flags_d[ST_PD] = 1'b1;
    end
    if (sleep_instr) begin
      flags_d[ST_TO] = 1'b1;
      flags_d[ST_PD] = 1'b0;
    end
    if (wdt_timeout) begin
      flags_d[ST_TO] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      pend_q <= '0;
      acc_q <= 8'h00;
      bsr_q <= '0;
      ptr_q <= '0;
      pclath_q <= 7'h00;
      intcon_q <= 8'h00;
      flags_q <= FLAGS_RESET;
      gpr_q <= '0;
      com_q <= '0;
      resp_valid_q <= 1'b0;
      resp_data_q <= 8'h00;
      pm_rd_q <= 1'b0;
      pm_addr_q <= '0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      acc_q <= acc_d;
      bsr_q <= bsr_d;
      ptr_q <= ptr_d;
      pclath_q <= pclath_d;
      intcon_q <= intcon_d;
      flags_q <= flags_d;
      gpr_q <= gpr_d;
      com_q <= com_d;
      resp_valid_q <= resp_valid_d;
      resp_data_q <= resp_data_d;
      pm_rd_q <= pm_rd_d;
      pm_addr_q <= pm_addr_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;
  assign resp_valid = resp_valid_q;
  assign resp_data = resp_data_q;
  assign working_accumulator = acc_q;
  assign alu_and_reset_flags = {3'h0, flags_q};
  assign pm_rd = pm_rd_q;
  assign pm_addr = pm_addr_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_pm_fetch;
    busy && pm_rd && !resp_valid ##1 resp_valid && !busy;
  endsequence

  property p_pm_extra;
    take && loc.pm && req.cmd == CMD_READ |=> s_pm_fetch;
  endproperty
  a_pm_extra: assert property (p_pm_extra) else $error("pm read not two cycles");

  property p_dm_fast;
    take && !loc.pm |=> resp_valid && !busy;
  endproperty
  a_dm_fast: assert property (p_dm_fast) else $error("data access not one cycle");

  property p_acc_low;
    state_q == ST_PM_WAIT && pend_q.cmd == CMD_READ && pend_q.to_acc
      |=> working_accumulator == $past(pm_rdata[7:0]);
  endproperty
  a_acc_low: assert property (p_acc_low) else $error("acc not low pm byte");

  property p_pm_addr;
    take && loc.pm && req.cmd != CMD_WRITE |=> pm_addr == $past(ptr_sel_val[PM_AW-1:0]);
  endproperty
  a_pm_addr: assert property (p_pm_addr) else $error("pm address wrong");

  property p_top_zero;
    take && !req.indirect && req.cmd == CMD_READ && req.faddr == OFF_STATUS
      |=> resp_data[7:5] == 3'h0 && alu_and_reset_flags[7:5] == 3'h0;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("status top bits set");

  property p_sleep;
    sleep_instr && !wdt_timeout && !clear_watchdog_instr
      |=> !alu_and_reset_flags[ST_PD] && alu_and_reset_flags[ST_TO];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

  property p_timeout;
    wdt_timeout |=> !alu_and_reset_flags[ST_TO] ##1 (alu_and_reset_flags[ST_TO]
      || !$past((clear_watchdog_instr || sleep_instr) && !wdt_timeout));
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out flag kept");

  property p_ro_flags;
    !clear_watchdog_instr && !sleep_instr && !wdt_timeout
      |=> $stable(alu_and_reset_flags[ST_TO:ST_PD]);
  endproperty
  a_ro_flags: assert property (p_ro_flags) else $error("to or pd changed");

  property p_bank;
    take && !req.indirect && req.cmd == CMD_WRITE && req.faddr == OFF_BSR
      |=> bsr_q == $past(req.operand[BANK_W-1:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select not loaded");

  property p_zero;
    take && !loc.pm && req.cmd == CMD_ALU && req.to_acc && aff[2]
      |=> alu_and_reset_flags[ST_Z] == (working_accumulator == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_rot;
    take && !loc.pm && req.cmd == CMD_ALU && req.op == ALU_RRC
      |=> alu_and_reset_flags[ST_C] == $past(a_val[0]);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate carry wrong");

  property p_unimpl;
    take && !req.indirect && req.cmd == CMD_READ && req.faddr >= OFF_SFR
      && req.faddr < OFF_GPR |=> resp_data == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented read nonzero");

endmodule
`default_nettype wire

// [bdm_pm_model.sv]
`default_nettype none
module bdm_pm_model
  import bdm_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic pm_rd,
  input wire logic [AW-1:0] pm_addr,
  output logic [PM_DW-1:0] pm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PM_DW-1:0] last_q = '0;
  logic [PM_DW-1:0] word;
  // ----------------------------------------
  // Read-only program store
  // ----------------------------------------
  // No write path at all
  assign word = 14'h2a5c ^ PM_DW'(pm_addr);
  // Outside a read the bus never repeats the last word
  assign pm_rdata = pm_rd ? word : ~last_q;
  always_ff @(posedge clk) begin
    last_q <= pm_rdata;
  end
endmodule
`default_nettype wire

// [banked_data_memory_and_alu_flags_test.sv]
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end
module banked_data_memory_and_alu_flags_test
  import bdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PMW = 4096;
  localparam int AW = 12;
  logic clk;
  logic resetn;
  bdm_req_t req;
  logic cw;
  logic sl;
  logic wt;
  logic [PM_DW-1:0] pm_rdata;
  logic busy;
  logic resp_valid;
  logic [7:0] resp_data;
  logic [7:0] working_accumulator;
  logic [7:0] alu_and_reset_flags;
  logic pm_rd;
  logic [AW-1:0] pm_addr;
  int n_mismatch;
  int n_tests;
  int lat;
  int k;
  logic [7:0] rd;
  logic [AW-1:0] seen_addr;
  logic seen_busy;
  logic [15:0] ex;
  bdm_alu_t ops[10] = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB, ALU_AND,
                        ALU_IOR, ALU_XOR, ALU_PASS, ALU_RRC, ALU_RLC};
  logic [7:0] av[10] = '{8'h0f, 8'hff, 8'h05, 8'h00, 8'hf0, 8'h00, 8'h3c, 8'h80, 8'h01, 8'h80};
  logic [7:0] bv[10] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h0f, 8'h00, 8'h3c, 8'h11, 8'h00, 8'h00};

  bdm_core #(
    .PM_WORDS(PMW)
  ) i_dut (
    .clk(clk),
    .resetn(resetn),
    .req(req),
    .clear_watchdog_instr(cw),
    .sleep_instr(sl),
    .wdt_timeout(wt),
    .pm_rdata(pm_rdata),
    .busy(busy),
    .resp_valid(resp_valid),
    .resp_data(resp_data),
    .working_accumulator(working_accumulator),
    .alu_and_reset_flags(alu_and_reset_flags),
    .pm_rd(pm_rd),
    .pm_addr(pm_addr)
  );

  bdm_pm_model #(
    .AW(AW)
  ) i_pm (
    .clk(clk),
    .pm_rd(pm_rd),
    .pm_addr(pm_addr),
    .pm_rdata(pm_rdata)
  );

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic go(input bdm_cmd_t c, input bdm_alu_t o, input logic ind, input logic ps,
                    input logic [6:0] fa, input logic [7:0] d, input logic ta);
    int i;
    @(posedge clk);
    req <= '{valid: 1'b1, cmd: c, op: o, indirect: ind, ptr_sel: ps, faddr: fa,
             operand: d, to_acc: ta};
    @(posedge clk);
    req <= '0;
    seen_addr = '0;
    seen_busy = 1'b0;
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      if (pm_rd === 1'b1) begin
        seen_addr = pm_addr;
      end
      if (busy === 1'b1) begin
        seen_busy = 1'b1;
      end
      if (resp_valid === 1'b1) begin
        break;
      end
    end
    if (i == 8) begin
      n_mismatch++;
      report_and_stop();
    end else begin
      rd = resp_data;
      lat = i;
    end
  endtask

  task automatic wr(input logic [6:0] fa, input logic [7:0] d);
    go(CMD_WRITE, ALU_ADD, 1'b0, 1'b0, fa, d, 1'b0);
  endtask

  task automatic rdd(input logic [6:0] fa);
    go(CMD_READ, ALU_ADD, 1'b0, 1'b0, fa, 8'h00, 1'b0);
  endtask

  task automatic pulse(input logic [2:0] e);
    @(posedge clk);
    {cw, sl, wt} <= e;
    @(posedge clk);
    {cw, sl, wt} <= 3'b000;
    @(negedge clk);
  endtask

  // Result in the upper byte, expected status in the lower byte
  function automatic logic [15:0] exp_alu(bdm_alu_t o, logic [7:0] a, logic [7:0] b);
    logic [7:0] bb;
    logic ci;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [2:0] f;
    bb = (o == ALU_SUB) ? ~b : b;
    ci = (o == ALU_SUB);
    s = {1'b0, a} + {1'b0, bb} + 9'(ci);
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(ci);
    f = 3'b000;
    case (o)
      ALU_ADD, ALU_SUB: begin
        r = s[7:0];
        f[1] = h[4];
        f[0] = s[8];
      end
      ALU_AND: r = a & b;
      ALU_IOR: r = a | b;
      ALU_XOR: r = a ^ b;
      ALU_PASS: r = a;
      ALU_RRC: begin
        r = {1'b0, a[7:1]};
        f[0] = a[0];
      end
      default: begin
        r = {a[6:0], 1'b0};
        f[0] = a[7];
      end
    endcase
    if (o != ALU_RRC && o != ALU_RLC) begin
      f[2] = (r == 8'h00);
    end
    return {r, 5'b00011, f};
  endfunction

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    resetn = 1'b0;
    req = '0;
    cw = 1'b0;
    sl = 1'b0;
    wt = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    `CHK("flags after reset", 8'h18, alu_and_reset_flags)
    `CHK("acc after reset", 8'h00, working_accumulator)
    wr(OFF_BSR, 8'h03);
    wr(OFF_GPR, 8'ha5);
    wr(OFF_COMMON, 8'h3c);
    wr(OFF_BSR, 8'h1f);
    wr(7'h6f, 8'h77);
    wr(OFF_BSR, 8'h00);
    wr(OFF_GPR, 8'h5a);
    rdd(OFF_COMMON);
    `CHK("common ram", 8'h3c, rd)
    `CHK("direct latency", 0, lat)
    `CHK("direct busy", 1'b0, seen_busy)
    rdd(OFF_GPR);
    `CHK("bank 0 ram", 8'h5a, rd)
    rdd(OFF_SFR);
    `CHK("unimplemented", 8'h00, rd)
    wr(OFF_BSR, 8'h1f);
    rdd(OFF_BSR);
    `CHK("bank select mirror", 8'h1f, rd)
    rdd(7'h6f);
    `CHK("bank 31 ram", 8'h77, rd)
    wr(OFF_BSR, 8'h03);
    rdd(OFF_GPR);
    `CHK("bank 3 ram", 8'ha5, rd)
    wr(OFF_P0_HI, 8'h0f);
    wr(OFF_P0_LO, 8'hef);
    go(CMD_READ, ALU_ADD, 1'b1, 1'b0, 7'h00, 8'h00, 1'b0);
    `CHK("pointer 0 data", 8'h77, rd)
    wr(OFF_P1_HI, 8'h92);
    wr(OFF_P1_LO, 8'h34);
    go(CMD_READ, ALU_ADD, 1'b1, 1'b1, 7'h00, 8'h00, 1'b1);
    `CHK("pm address", 12'h234, seen_addr)
    `CHK("pm low byte", 8'h68, working_accumulator)
    `CHK("pm latency", 1, lat)
    `CHK("pm busy", 1'b1, seen_busy)
    go(CMD_WRITE, ALU_ADD, 1'b1, 1'b1, 7'h00, 8'hff, 1'b0);
    go(CMD_READ, ALU_ADD, 1'b1, 1'b1, 7'h00, 8'h00, 1'b0);
    `CHK("pm after write", 8'h68, rd)
    // A dropped program memory write must not land at the data alias either
    wr(OFF_P0_HI, 8'h8f);
    go(CMD_WRITE, ALU_ADD, 1'b1, 1'b0, 7'h00, 8'hee, 1'b0);
    wr(OFF_P0_HI, 8'h0f);
    go(CMD_READ, ALU_ADD, 1'b1, 1'b0, 7'h00, 8'h00, 1'b0);
    `CHK("data alias after pm write", 8'h77, rd)
    go(CMD_WRITE, ALU_ADD, 1'b1, 1'b0, 7'h00, 8'h99, 1'b0);
    go(CMD_READ, ALU_ADD, 1'b1, 1'b0, 7'h00, 8'h00, 1'b0);
    `CHK("pointer 0 write", 8'h99, rd)
    for (k = 0; k < 10; k++) begin
      wr(OFF_STATUS, 8'h00);
      wr(7'h21, av[k]);
      go(CMD_ALU, ops[k], 1'b0, 1'b0, 7'h21, bv[k], 1'b1);
      ex = exp_alu(ops[k], av[k], bv[k]);
      `CHK("alu result", ex[15:8], working_accumulator)
      `CHK("alu flags", ex[7:0], alu_and_reset_flags)
    end
    wr(OFF_STATUS, 8'h07);
    `CHK("status write", 8'h1f, alu_and_reset_flags)
    rdd(OFF_STATUS);
    `CHK("status read", 8'h1f, rd)
    go(CMD_ALU, ALU_ADD, 1'b0, 1'b0, OFF_STATUS, 8'h01, 1'b0);
    `CHK("alu into status", 8'h1a, alu_and_reset_flags)
    pulse(3'b010);
    `CHK("sleep", 2'b10, alu_and_reset_flags[4:3])
    pulse(3'b001);
    `CHK("timeout", 2'b00, alu_and_reset_flags[4:3])
    pulse(3'b100);
    `CHK("clear watchdog", 2'b11, alu_and_reset_flags[4:3])
    pulse(3'b011);
    `CHK("sleep with timeout", 2'b00, alu_and_reset_flags[4:3])
    wr(OFF_STATUS, 8'hff);
    `CHK("read-only flags", 8'h07, alu_and_reset_flags)
    report_and_stop();
  end
endmodule
`default_nettype wire
